/* File: design/serial_control_port.v */
// serial control port: shift engine, staging buffer and update transfer
// Operation
// - write bits are taken on serial clock rising edges and read bits change on falling edges.
// - with chip select high all serial pin activity is ignored.
// - the separate readback pin drives data only in unidirectional mode.
// - an active-high port reset abandons a failed transfer and restarts the port.
// - a high update strobe copies every staging word into the active registers.
// - a config bit makes the update strobe pin an output that signals the transfer itself.
// - three profile-select bits choose one of eight profiles for the synthesizer core.
// - any change of a profile-select bit triggers the same transfer as an update strobe.
// - a sync clock runs at one quarter of the system clock.
// - full reset clears all storage and restores defaults.
`include "serial_port_regs.vh"
`default_nettype none
module serial_control_port #(
   parameter AW = `ADDR_W,
   parameter DW = `DATA_W,
   parameter DEPTH = `REG_COUNT
) (
   input wire clk_in,
   input wire rst_in,
   input wire sclk_in,
   input wire cs_n_in,
   input wire sdio_in,
   output reg sdio_out,
   output reg sdio_oe_n_out,
   output reg serial_readback_out,
   input wire port_reset_in,
   input wire update_in,
   output reg update_out,
   output reg update_oe_n_out,
   input wire profile_select_bit0,
   input wire profile_select_bit1,
   input wire profile_select_bit2,
   output reg sync_clk_out,
   output reg [2:0] profile_out,
   input wire [AW-1:0] active_addr_in,
   output wire [DW-1:0] active_data_out,
   output reg [DW-1:0] config_out
);
   localparam ST_CMD = 2'd0;
   localparam ST_WDATA = 2'd1;
   localparam ST_RDATA = 2'd2;
   localparam ST_DONE = 2'd3;
   localparam ST_IDLE = 2'd0;
   localparam ST_COPY = 2'd1;

   // two-flop synchronisers for every pin input
   reg [1:0] sclk_s_r, cs_s_r, sdio_s_r, prst_s_r, upd_s_r;
   reg [2:0] prof_a_r, prof_b_r;
   reg sclk_d_r;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_s_r <= 2'h0;
         cs_s_r <= 2'h3;
         sdio_s_r <= 2'h0;
         prst_s_r <= 2'h0;
         upd_s_r <= 2'h0;
         prof_a_r <= 3'h0;
         prof_b_r <= 3'h0;
         sclk_d_r <= 1'b0;
      end else begin
         sclk_s_r <= {sclk_s_r[0], sclk_in};
         cs_s_r <= {cs_s_r[0], cs_n_in};
         sdio_s_r <= {sdio_s_r[0], sdio_in};
         prst_s_r <= {prst_s_r[0], port_reset_in};
         upd_s_r <= {upd_s_r[0], update_in};
         prof_a_r <= {profile_select_bit2, profile_select_bit1, profile_select_bit0};
         prof_b_r <= prof_a_r;
         sclk_d_r <= sclk_s_r[1];
      end
   end

   wire cs_act = ~cs_s_r[1];
   wire sclk_rise = cs_act & sclk_s_r[1] & ~sclk_d_r;
   wire sclk_fall = cs_act & ~sclk_s_r[1] & sclk_d_r;
   wire unidir = config_out[`CFG_UNIDIR_BIT];

   // serial engine: 8-bit instruction then DW data bits, msb first
   reg [1:0] st_r;
   reg [5:0] cnt_r;
   reg [7:0] cmd_r;
   reg [DW-1:0] shift_r;
   reg [DW-1:0] rd_shift_r;
   reg stage_we_r;
   reg [AW-1:0] stage_waddr_r;
   reg [DW-1:0] stage_wdata_r;
   reg load_rd_r;
   reg load_rd2_r;
   wire [DW-1:0] stage_rd_data;
   wire [AW-1:0] cmd_addr = cmd_r[AW-1:0];

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= ST_CMD;
         cnt_r <= 6'h00;
         cmd_r <= 8'h00;
         shift_r <= {DW{1'b0}};
         rd_shift_r <= {DW{1'b0}};
         stage_we_r <= 1'b0;
         stage_waddr_r <= {AW{1'b0}};
         stage_wdata_r <= {DW{1'b0}};
         load_rd_r <= 1'b0;
         load_rd2_r <= 1'b0;
         config_out <= `CFG_RESET;
      end else begin
         stage_we_r <= 1'b0;
         load_rd_r <= 1'b0;
         // staging read data lags its address by one clock
         load_rd2_r <= load_rd_r;
         if (prst_s_r[1] | ~cs_act) begin
            // port reset or deselect drops any partial transfer
            st_r <= ST_CMD;
            cnt_r <= 6'h00;
         end else if (load_rd2_r) begin
            rd_shift_r <= stage_rd_data;
         end else begin
            case (st_r)
               ST_CMD: begin
                  if (sclk_rise) begin
                     cmd_r <= {cmd_r[6:0], sdio_s_r[1]};
                     if (cnt_r == 6'd7) begin
                        cnt_r <= 6'h00;
                        st_r <= cmd_r[6] ? ST_RDATA : ST_WDATA;
                        load_rd_r <= cmd_r[6];
                     end else begin
                        cnt_r <= cnt_r + 6'd1;
                     end
                  end
               end
               ST_WDATA: begin
                  if (sclk_rise) begin
                     shift_r <= {shift_r[DW-2:0], sdio_s_r[1]};
                     if (cnt_r == DW - 1) begin
                        st_r <= ST_DONE;
                        stage_we_r <= 1'b1;
                        stage_waddr_r <= cmd_addr;
                        stage_wdata_r <= {shift_r[DW-2:0], sdio_s_r[1]};
                        if (cmd_addr == `CFG_ADDR) begin
                           config_out <= {shift_r[DW-2:0], sdio_s_r[1]};
                        end
                     end else begin
                        cnt_r <= cnt_r + 6'd1;
                     end
                  end
               end
               ST_RDATA: begin
                  if (sclk_fall) begin
                     // first fall only presents the msb; drive holds through the last rise
                     if (cnt_r != 6'h00) begin
                        rd_shift_r <= {rd_shift_r[DW-2:0], 1'b0};
                     end
                     if (cnt_r == DW) begin
                        st_r <= ST_DONE;
                     end else begin
                        cnt_r <= cnt_r + 6'd1;
                     end
                  end
               end
               default: begin
                  st_r <= ST_DONE;
               end
            endcase
         end
      end
   end

   // readback drive: the two-way pin only in bidirectional mode
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sdio_out <= 1'b0;
         sdio_oe_n_out <= 1'b1;
         serial_readback_out <= 1'b0;
      end else begin
         sdio_out <= rd_shift_r[DW-1];
         sdio_oe_n_out <= ~(cs_act & (st_r == ST_RDATA) & ~unidir);
         serial_readback_out <= unidir & cs_act & (st_r == ST_RDATA) & rd_shift_r[DW-1];
      end
   end

   // quarter-rate sync clock; strobes sampled one clock before its rising edge
   reg [1:0] div_r;
   reg [2:0] prof_last_r;
   reg [1:0] ust_r;
   reg [5:0] copy_idx_r;
   reg upd_pend_r;
   wire sync_rise = (div_r == 2'd1);
   wire upd_is_out = config_out[`CFG_UPDATE_OUT_BIT];
   wire prof_chg = sync_rise & (prof_b_r != prof_last_r);
   wire upd_hit = sync_rise & ~upd_is_out & upd_s_r[1];
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_r <= 2'd0;
         sync_clk_out <= 1'b0;
         prof_last_r <= 3'h0;
         profile_out <= 3'h0;
         ust_r <= ST_IDLE;
         copy_idx_r <= 6'h00;
         upd_pend_r <= 1'b0;
         update_out <= 1'b0;
         update_oe_n_out <= 1'b1;
      end else begin
         div_r <= div_r + 2'd1;
         // high on phases 2 and 3 so the first rise after reset keeps the 4-clock spacing
         sync_clk_out <= (div_r == 2'd2) | (div_r == 2'd3);
         update_oe_n_out <= ~upd_is_out;
         if (sync_rise) begin
            prof_last_r <= prof_b_r;
            profile_out <= prof_b_r;
         end
         // a request arriving mid-copy is held so it is not lost
         if ((upd_hit | prof_chg) & (ust_r == ST_COPY)) begin
            upd_pend_r <= 1'b1;
         end else if (ust_r == ST_IDLE) begin
            upd_pend_r <= 1'b0;
         end
         case (ust_r)
            ST_IDLE: begin
               update_out <= 1'b0;
               if (upd_hit | prof_chg | upd_pend_r) begin
                  ust_r <= ST_COPY;
                  copy_idx_r <= 6'h00;
               end
            end
            ST_COPY: begin
               update_out <= upd_is_out;
               if (copy_idx_r == DEPTH) begin
                  ust_r <= ST_IDLE;
               end else begin
                  copy_idx_r <= copy_idx_r + 6'd1;
               end
            end
            default: begin
               ust_r <= ST_IDLE;
            end
         endcase
      end
   end

   // staging read port serves readback, or copy source during transfer
   wire copying = (ust_r == ST_COPY);
   wire [AW-1:0] stage_raddr = copying ? copy_idx_r[AW-1:0] : cmd_addr;
   reg copy_we_r;
   reg [AW-1:0] copy_waddr_r;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         copy_we_r <= 1'b0;
         copy_waddr_r <= {AW{1'b0}};
      end else begin
         copy_we_r <= copying & (copy_idx_r != DEPTH);
         copy_waddr_r <= copy_idx_r[AW-1:0];
      end
   end

   reg_bank_mem #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_stage (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(stage_we_r),
      .wr_addr_in(stage_waddr_r),
      .wr_data_in(stage_wdata_r),
      .rd_addr_in(stage_raddr),
      .rd_data_out(stage_rd_data)
   );

   reg_bank_mem #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_active (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(copy_we_r),
      .wr_addr_in(copy_waddr_r),
      .wr_data_in(stage_rd_data),
      .rd_addr_in(active_addr_in),
      .rd_data_out(active_data_out)
   );
endmodule // serial_control_port
`default_nettype wire

/* File: shared/serial_port_regs.vh */
// constants for the serial control port with staged update
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
`define ADDR_W 5
`define DATA_W 32
`define REG_COUNT 32
`define CMD_READ_BIT 7
`define CFG_ADDR 5'h00
`define CFG_RESET 32'h00000000
`define CFG_UNIDIR_BIT 1
`define CFG_UPDATE_OUT_BIT 23
`define SYNC_DIV 4
`define PROFILE_COUNT 8
`endif

/* File: design/reg_bank_mem.v */
// register bank memory with registered read data, used for staging and active copies
`default_nettype none
module reg_bank_mem #(
   parameter DEPTH = 32,
   parameter AW = 5,
   parameter DW = 32
) (
   input wire clk_in,
   input wire rst_in,
   input wire wr_en_in,
   input wire [AW-1:0] wr_addr_in,
   input wire [DW-1:0] wr_data_in,
   input wire [AW-1:0] rd_addr_in,
   output reg [DW-1:0] rd_data_out
);
   reg [DW-1:0] mem_r [0:DEPTH-1];
   integer i;
   // write port plus registered read; reset clears every word
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= {DW{1'b0}};
         end
         rd_data_out <= {DW{1'b0}};
      end else begin
         if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= mem_r[rd_addr_in];
      end
   end
endmodule // reg_bank_mem
`default_nettype wire

/* File: tb/serial_control_port_sva.sv */
// assertion checker for the serial control port
`default_nettype none
module serial_control_port_sva #(parameter DW = 32) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic port_reset_in,
   input wire logic profile_select_bit0,
   input wire logic profile_select_bit1,
   input wire logic profile_select_bit2,
   input wire logic sdio_oe_n_out,
   input wire logic serial_readback_out,
   input wire logic update_out,
   input wire logic update_oe_n_out,
   input wire logic sync_clk_out,
   input wire logic [2:0] profile_out,
   input wire logic [DW-1:0] config_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_sync_quarter: assert property (
      $rose(sync_clk_out) |-> ##4 $rose(sync_clk_out)) else $error("sync clock not quarter");
   a_cs_quiet: assert property (
      cs_n_in [*6] |-> sdio_oe_n_out) else $error("sdio driven while deselected");
   a_port_reset: assert property (
      port_reset_in [*6] |-> sdio_oe_n_out) else $error("sdio driven in port reset");
   a_uni_input: assert property (
      config_out[1] && $past(config_out[1]) |-> sdio_oe_n_out) else $error("sdio out in unidir");
   a_bidir_quiet: assert property (
      !config_out[1] && !$past(config_out[1]) |-> !serial_readback_out)
      else $error("readback pin active in bidir");
   a_strobe_dir: assert property (
      update_out |-> !update_oe_n_out) else $error("strobe driven in input mode");
   a_copy_hold: assert property (
      $rose(update_out) |=> update_out [*8]) else $error("copy strobe too short");
   a_profile_follow: assert property (
      $stable({profile_select_bit2, profile_select_bit1, profile_select_bit0}) [*8]
      |-> profile_out == {profile_select_bit2, profile_select_bit1, profile_select_bit0})
      else $error("profile not taken");
   a_reset_state: assert property (
      $fell(rst_in) |-> !update_out && sdio_oe_n_out && config_out == '0)
      else $error("outputs not cleared by reset");
endmodule // serial_control_port_sva
bind serial_control_port serial_control_port_sva #(.DW(DW)) u_sva (.clk_in, .rst_in,
   .cs_n_in, .port_reset_in, .profile_select_bit0, .profile_select_bit1,
   .profile_select_bit2, .sdio_oe_n_out, .serial_readback_out, .update_out,
   .update_oe_n_out, .sync_clk_out, .profile_out, .config_out);
`default_nettype wire

/* File: tb/host_serial_model.sv */
// host controller model driving the serial control pins
`default_nettype none
module host_serial_model (
   input wire logic clk_in,
   input wire logic sdio_line_in,
   input wire logic readback_in,
   output var logic sclk_out,
   output var logic cs_n_out,
   output var logic sdio_out,
   output var logic sdio_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // serial clock stands low outside frames
   initial begin
      sclk_out = 0;
      cs_n_out = 1;
      sdio_out = 0;
      sdio_oe_n_out = 1;
   end
   task automatic half;
      repeat (16) @(negedge clk_in);
   endtask
   // 8 command bits then 32 data bits, msb first
   task automatic frame(input logic [7:0] cmd, input logic [31:0] wd, input logic uni,
         output logic [31:0] rd);
      logic [39:0] sh;
      sh = {cmd, wd};
      rd = 32'h0;
      cs_n_out = 0;
      half;
      for (int i = 39; i >= 0; i--) begin
         sdio_out = sh[i];
         sdio_oe_n_out = cmd[7] && i < 32; // let go so the device can answer
         half;
         sclk_out = 1;
         if (i < 32)
            rd[i] = uni ? readback_in : sdio_line_in;
         half;
         sclk_out = 0;
      end
      half;
      cs_n_out = 1;
      sdio_oe_n_out = 1;
      half; // deselect must stand long enough to be seen
   endtask
   // a cut-off frame: n one-bits with chip select left low
   task automatic stray(input int n);
      cs_n_out = 0;
      half;
      repeat (n) begin
         sdio_out = 1;
         sdio_oe_n_out = 0;
         half;
         sclk_out = 1;
         half;
         sclk_out = 0;
      end
   endtask
endmodule // host_serial_model
`default_nettype wire

/* File: tb/serial_control_port_with_update_test.sv */
// self-checking bench for the serial control port with staged update
`default_nettype none
module serial_control_port_with_update_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, rst_in = 1, sclk, cs_n, h_sd, h_oe_n, sd_o, sd_oe_n, rb, last = 0;
   logic port_rst = 0, upd = 0, upd_o, upd_oe_n, sync, seen = 0;
   logic [2:0] prof = 0, prof_o;
   logic [4:0] a_addr = 0;
   logic [31:0] a_data, cfg, rd;
   integer n_errors = 0, checks = 0;
   // undriven line toggles so a stale bit cannot pass
   wire logic sdio = !sd_oe_n ? sd_o : !h_oe_n ? h_sd : ~last;
   always #2.5 clk_in = ~clk_in;
   // line history and watch for sdio driven in unidir mode
   always @(posedge clk_in) begin
      last <= sdio;
      if (!sd_oe_n && cfg[1])
         seen <= 1;
   end
   serial_control_port dut (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .sdio_in(sdio), .sdio_out(sd_o), .sdio_oe_n_out(sd_oe_n), .serial_readback_out(rb),
      .port_reset_in(port_rst), .update_in(upd), .update_out(upd_o),
      .update_oe_n_out(upd_oe_n), .profile_select_bit0(prof[0]), .profile_select_bit1(prof[1]),
      .profile_select_bit2(prof[2]), .sync_clk_out(sync), .profile_out(prof_o),
      .active_addr_in(a_addr), .active_data_out(a_data), .config_out(cfg));
   host_serial_model host (.clk_in(clk_in), .sdio_line_in(sdio), .readback_in(rb),
      .sclk_out(sclk), .cs_n_out(cs_n), .sdio_out(h_sd), .sdio_oe_n_out(h_oe_n));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic active(input logic [4:0] a, input logic [31:0] exp, input string what);
      a_addr = a;
      repeat (2) @(negedge clk_in);
      chk(what, exp, a_data);
   endtask
   // pins change just after a sync clock rise
   task automatic on_sync(input logic u, input logic [2:0] p);
      @(posedge sync);
      @(negedge clk_in);
      upd = u;
      prof = p;
   endtask
   task automatic t_stage;
      chk("config", 32'h0, cfg);
      host.frame(8'h03, 32'ha5c3_0f96, 0, rd);
      host.frame(8'h83, 32'h0, 0, rd);
      chk("bidir read", 32'ha5c3_0f96, rd);
      active(5'h03, 32'h0, "staged");
      on_sync(1, prof);
      on_sync(0, prof);
      repeat (80) @(negedge clk_in);
      active(5'h03, 32'ha5c3_0f96, "strobe copy");
      $display("test stage done");
   endtask
   task automatic t_profile;
      for (int i = 0; i < 8; i++) begin
         on_sync(0, i[2:0]);
         repeat (8) @(negedge clk_in);
         chk("profile", {29'h0, i[2:0]}, {29'h0, prof_o});
      end
      host.frame(8'h04, 32'h1234_5678, 0, rd);
      active(5'h04, 32'h0, "profile staged");
      on_sync(0, 3'h2);
      repeat (80) @(negedge clk_in);
      active(5'h04, 32'h1234_5678, "profile copy");
      $display("test profile done");
   endtask
   task automatic t_unidir;
      host.frame(8'h00, 32'h2, 0, rd);
      chk("config", 32'h2, cfg);
      host.frame(8'h83, 32'h0, 1, rd);
      chk("unidir read", 32'ha5c3_0f96, rd);
      chk("sdio drive", 32'h0, {31'h0, seen});
      $display("test unidir done");
   endtask
   task automatic t_update_pin;
      host.stray(5);
      port_rst = 1;
      repeat (8) @(negedge clk_in);
      port_rst = 0;
      repeat (4) @(negedge clk_in);
      host.frame(8'h00, 32'h0080_0002, 0, rd);
      chk("config", 32'h0080_0002, cfg);
      chk("strobe oe_n", 32'h0, {31'h0, upd_oe_n});
      on_sync(0, 3'h5);
      for (int i = 0; i < 80 && upd_o !== 1'b1; i++)
         @(negedge clk_in);
      chk("strobe out", 32'h1, {31'h0, upd_o});
      $display("test update pin done");
   endtask
   // mid-run full reset clears config and the active bank
   task automatic t_reset;
      rst_in = 1;
      repeat (10) @(negedge clk_in);
      rst_in = 0;
      chk("config", 32'h0, cfg);
      chk("strobe oe_n", 32'h1, {31'h0, upd_oe_n});
      active(5'h03, 32'h0, "reset active");
      $display("test reset done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence after a 10 cycle reset
   initial begin
      repeat (10) @(negedge clk_in);
      rst_in = 0;
      repeat (4) @(negedge clk_in);
      t_stage;
      t_profile;
      t_unidir;
      t_update_pin;
      t_reset;
      test_done;
   end
   // watchdog, about five times the expected run
   initial begin
      repeat (40000) @(posedge clk_in);
      n_errors++;
      test_done;
   end
endmodule // serial_control_port_with_update_test
`default_nettype wire
